// File: hdl/uhie_pkg.sv
// uhie_pkg: register map, field positions and carrier types for the
// host controller interrupt status / enable block.
// assumes a 32-bit register port with byte offsets as printed.
package uhie_pkg;
   localparam int          DATA_W        = 32;
   localparam int          ADDR_W        = 8;
   localparam int          CNT_W         = 2;
   // register offsets (byte addresses)
   localparam logic [7:0]  OFS_FLAGS     = 8'h0c;
   localparam logic [7:0]  OFS_ENABLES   = 8'h10;
   localparam logic [7:0]  OFS_EN_CLEAR  = 8'h14;
   // field positions
   localparam int          BIT_OVERRUN   = 0;
   localparam int          BIT_DONE_WB   = 1;
   localparam int          BIT_FRAME_ST  = 2;
   localparam int          BIT_RESUME    = 3;
   localparam int          BIT_FATAL     = 4;
   localparam int          BIT_FRM_OVF   = 5;
   localparam int          BIT_ROOT_HUB  = 6;
   localparam int          BIT_OWNER     = 30;
   localparam int          BIT_MASTER    = 31;
   localparam int          NUM_EVENTS    = 8;
   localparam int          FRM_MSB       = 15;
   // implemented bits of each register
   localparam logic [31:0] FLAG_MASK     = 32'h4000_007f;
   localparam logic [31:0] ENABLE_MASK   = 32'hc000_007f;
   localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
   localparam logic [1:0]  CNT_RESET     = 2'h0;
   localparam logic [1:0]  CNT_STEP      = 2'h1;

   // register port request from the bus side
   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [7:0]        addr;
      logic [31:0]       wdata;
   } uhie_req_t;

   // event inputs from the controller core: one-cycle pulses, except two levels
   typedef struct packed {
      logic        owner_req;      // ownership_request set by software
      logic        root_hub_chg;   // root_hub_state / root_port_state changed
      logic        frame_msb_chg;  // frame_counter bit 15 toggled
      logic        shared_frm_upd; // shared_frame_counter written
      logic        sys_error;      // non-usb system error
      logic        resume_sig;     // level: downstream resume signalling
      logic        sw_resume;      // level: software entered bus_resume_state
      logic        frame_start;    // sof token issued
      logic        done_written;   // shared_done_queue_head written
      logic        sched_overrun;  // frame schedule overran
   } uhie_evt_t;
endpackage : uhie_pkg

// File: hdl/uhie_event_flags.sv
// uhie_event_flags: sticky write-one-to-clear flag bank, one bit per slot.
// assumes set pulses and clear strobes come from the mclk domain.
`timescale 1ns/1ps
`default_nettype none
module uhie_event_flags #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         reset,
   // set and clear
   input  wire logic [W-1:0] set_bits,
   input  wire logic [W-1:0] clr_bits,
   input  wire logic [W-1:0] keep_mask,
   // state
   output logic      [W-1:0] flags_q
);
   logic [W-1:0] flags_d;

   ////////////////////////////////////////////////////////////////////
   // next value per bit: set beats clear, unimplemented bits stay zero
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
         flags_d[i] = keep_mask[i] & (set_bits[i] | (flags_q[i] & ~clr_bits[i]));
      end
   end

   // flag register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end
endmodule : uhie_event_flags
`default_nettype wire

// File: hdl/uhie_irq_core.sv
// uhie_irq_core: interrupt status, enable and disable registers of a
// full/low-speed usb host controller, with host irq and smi outputs.
// assumes event inputs are synchronous to mclk; register port is a
// simple one-cycle read/write strobe pair, read data one cycle later.
// Notes on behaviour
// - defined events set their status flag, which stays until software clears it
// - host irq only with flag set, its enable set, and master enable set
// - writing 1 clears a flag, 0 leaves it, software never sets one
// - controller logic never clears flags; only write-one or reset does
// - ownership request sets ownership flag; if enabled, smi is raised at once
// - without an smi pin the ownership flag reads always zero
// - root hub or port status change sets the root hub change flag
// - frame counter msb toggle or shared frame copy update sets overflow flag
// - system error sets fatal flag and halts all processing and signalling
// - resume flag set on rising downstream resume, not on software resume
// - frame start flag set together with the sof token
// - done-written flag set after head write-back; no new write-back while set
// - schedule overrun sets overrun flag and increments two-bit counter
// - enable register: writing 1 sets a bit, 0 leaves it; read returns it
// - each enable gates its flag; bit 31 masters all others
// - disable port: writing 1 clears enable bit; read returns enable value
// - overrun counter starts at zero, wraps, counts even if flag already set
`timescale 1ns/1ps
`default_nettype none
module uhie_irq_core #(
   parameter bit HAS_SMI_PIN = 1'b1
) (
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                reset,
   // register port
   input  wire uhie_pkg::uhie_req_t req,
   output logic               [31:0] rdata_q,
   output logic                      rvalid_q,
   // controller events
   input  wire uhie_pkg::uhie_evt_t evt,
   // controller control
   output logic                      halt_q,
   output logic                      done_wb_allow_q,
   output logic                [1:0] overrun_count_q,
   // interrupt outputs
   output logic                      host_irq_q,
   output logic                      system_mgmt_irq_pin_n_q
);
   logic [31:0] flags;
   logic [31:0] set_bits;
   logic [31:0] clr_bits;
   logic [31:0] keep_mask;
   logic [31:0] en_q;
   logic [31:0] en_d;
   logic [1:0]  cnt_d;
   logic        resume_q;
   logic        resume_d;
   logic        wr_flags;
   logic        wr_en;
   logic        wr_dis;
   logic [31:0] rdata_d;
   logic        rvalid_d;
   logic        halt_d;
   logic        irq_d;
   logic        smi_n_d;
   logic        done_allow_d;

   ////////////////////////////////////////////////////////////////////
   // address decode
   always_comb begin
      wr_flags = 1'b0;
      wr_en    = 1'b0;
      wr_dis   = 1'b0;
      if (req.wr && req.addr == uhie_pkg::OFS_FLAGS) begin
         wr_flags = 1'b1;
      end else if (req.wr && req.addr == uhie_pkg::OFS_ENABLES) begin
         wr_en = 1'b1;
      end else if (req.wr && req.addr == uhie_pkg::OFS_EN_CLEAR) begin
         wr_dis = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event sources into flag set bits
   always_comb begin
      set_bits = '0;
      set_bits[uhie_pkg::BIT_OWNER]    = evt.owner_req;
      set_bits[uhie_pkg::BIT_ROOT_HUB] = evt.root_hub_chg;
      set_bits[uhie_pkg::BIT_FRM_OVF]  = evt.frame_msb_chg | evt.shared_frm_upd;
      set_bits[uhie_pkg::BIT_FATAL]    = evt.sys_error;
      set_bits[uhie_pkg::BIT_RESUME]   = resume_d & ~resume_q & ~evt.sw_resume;
      set_bits[uhie_pkg::BIT_FRAME_ST] = evt.frame_start;
      set_bits[uhie_pkg::BIT_DONE_WB]  = evt.done_written & done_wb_allow_q;
      set_bits[uhie_pkg::BIT_OVERRUN]  = evt.sched_overrun;
      // write-one clears only; data never sets a flag
      clr_bits = wr_flags ? req.wdata : '0;
      keep_mask = uhie_pkg::FLAG_MASK;
      if (!HAS_SMI_PIN) begin
         keep_mask[uhie_pkg::BIT_OWNER] = 1'b0;
      end
   end

   // sticky status flags, set wins over a same-cycle clear
   uhie_event_flags #(
      .W (uhie_pkg::DATA_W)
   ) u_flags (
      .mclk      (mclk),
      .reset     (reset),
      .set_bits  (set_bits),
      .clr_bits  (clr_bits),
      .keep_mask (keep_mask),
      .flags_q   (flags)
   );

   ////////////////////////////////////////////////////////////////////
   // enable register, overrun counter and resume edge tracking
   always_comb begin
      en_d = en_q;
      if (wr_en) begin
         en_d = en_q | (req.wdata & uhie_pkg::ENABLE_MASK);
      end else if (wr_dis) begin
         en_d = en_q & ~req.wdata;
      end
      cnt_d = overrun_count_q;
      if (evt.sched_overrun) begin
         cnt_d = overrun_count_q + uhie_pkg::CNT_STEP;
      end
      resume_d = evt.resume_sig;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         en_q            <= uhie_pkg::RESET_VALUE;
         overrun_count_q <= uhie_pkg::CNT_RESET;
         resume_q        <= 1'b0;
      end else begin
         en_q            <= en_d;
         overrun_count_q <= cnt_d;
         resume_q        <= resume_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt outputs, halt and write-back gating
   always_comb begin
      // event flags gated by their enables and the master enable
      irq_d = en_d[uhie_pkg::BIT_MASTER] &
              (|(flags & en_d & uhie_pkg::FLAG_MASK &
                 ~(32'h1 << uhie_pkg::BIT_OWNER)));
      // ownership change goes to smi instead, immediately when unmasked
      smi_n_d = ~(HAS_SMI_PIN & flags[uhie_pkg::BIT_OWNER] &
                  en_d[uhie_pkg::BIT_OWNER] & en_d[uhie_pkg::BIT_MASTER]);
      halt_d = flags[uhie_pkg::BIT_FATAL] | evt.sys_error;
      done_allow_d = ~(flags[uhie_pkg::BIT_DONE_WB] | set_bits[uhie_pkg::BIT_DONE_WB]);
      rvalid_d = req.rd;
      rdata_d  = '0;
      if (req.rd && req.addr == uhie_pkg::OFS_FLAGS) begin
         rdata_d = flags;
      end else if (req.rd && req.addr == uhie_pkg::OFS_ENABLES) begin
         rdata_d = en_q;
      end else if (req.rd && req.addr == uhie_pkg::OFS_EN_CLEAR) begin
         rdata_d = en_q;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         host_irq_q              <= 1'b0;
         system_mgmt_irq_pin_n_q <= 1'b1;
         halt_q                  <= 1'b0;
         done_wb_allow_q         <= 1'b1;
         rvalid_q                <= 1'b0;
         rdata_q                 <= '0;
      end else begin
         host_irq_q              <= irq_d;
         system_mgmt_irq_pin_n_q <= smi_n_d;
         halt_q                  <= halt_d;
         done_wb_allow_q         <= done_allow_d;
         rvalid_q                <= rvalid_d;
         rdata_q                 <= rdata_d;
      end
   end
endmodule : uhie_irq_core
`default_nettype wire

// File: bench/uhie_irq_checker.sv
// uhie_irq_checker: port assertions for the interrupt status/enable core.
// assumes bind onto uhie_irq_core, one mclk domain, reset active high.
`timescale 1ns/1ps
`default_nettype none
module uhie_irq_checker #(parameter bit HAS_SMI_PIN = 1'b1) (
   // clock, reset and register port
   input wire logic                mclk,
   input wire logic                reset,
   input wire uhie_pkg::uhie_req_t req,
   input wire logic         [31:0] rdata_q,
   input wire logic                rvalid_q,
   // events and outputs
   input wire uhie_pkg::uhie_evt_t evt,
   input wire logic                halt_q,
   input wire logic                done_wb_allow_q,
   input wire logic          [1:0] overrun_count_q,
   input wire logic                host_irq_q,
   input wire logic                system_mgmt_irq_pin_n_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // writes that clear the fatal flag or the master enable
   wire clr4 = req.wr && req.addr == uhie_pkg::OFS_FLAGS && req.wdata[4];
   wire moff = req.wr && req.addr == uhie_pkg::OFS_EN_CLEAR && req.wdata[31];
   ////////////////////////////////////////////////////////////////////////////
   property p_cnt; evt.sched_overrun |=> overrun_count_q == $past(overrun_count_q) + 2'h1; endproperty
   a_cnt: assert property (p_cnt) else $error("overrun count");
   property p_halt; evt.sys_error |=> halt_q; endproperty
   a_halt: assert property (p_halt) else $error("no halt");
   property p_keep; halt_q && !clr4 && !$past(clr4) |=> halt_q; endproperty
   a_keep: assert property (p_keep) else $error("fatal flag lost");
   property p_done; evt.done_written && done_wb_allow_q |-> ##2 !done_wb_allow_q; endproperty
   a_done: assert property (p_done) else $error("write-back allowed");
   property p_irq; host_irq_q && !req.wr && !$past(req.wr) |=> host_irq_q; endproperty
   a_irq: assert property (p_irq) else $error("irq dropped");
   property p_moff; moff ##1 !req.wr |=> !host_irq_q; endproperty
   a_moff: assert property (p_moff) else $error("irq without master");
   property p_smi; !system_mgmt_irq_pin_n_q && !req.wr && !$past(req.wr) |=> !system_mgmt_irq_pin_n_q; endproperty
   a_smi: assert property (p_smi) else $error("smi dropped");
   property p_rv; rvalid_q |-> $past(req.rd); endproperty
   a_rv: assert property (p_rv) else $error("stray read data");
   property p_nosmi; HAS_SMI_PIN || system_mgmt_irq_pin_n_q; endproperty
   a_nosmi: assert property (p_nosmi) else $error("smi without pin");
   // main scenarios
   cover property (evt.sys_error);
   cover property ($rose(host_irq_q));
   cover property (overrun_count_q == 2'h3 ##1 overrun_count_q == 2'h0);
endmodule : uhie_irq_checker
bind uhie_irq_core uhie_irq_checker #(.HAS_SMI_PIN(HAS_SMI_PIN)) chk_u (.mclk(mclk), .reset(reset), .req(req),
   .rdata_q(rdata_q), .rvalid_q(rvalid_q), .evt(evt), .halt_q(halt_q), .done_wb_allow_q(done_wb_allow_q),
   .overrun_count_q(overrun_count_q), .host_irq_q(host_irq_q), .system_mgmt_irq_pin_n_q(system_mgmt_irq_pin_n_q));
`default_nettype wire

// File: bench/uhie_host_model.sv
// uhie_host_model: driver-side register traffic on the strobe port.
// assumes mclk from the bench; requests move on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module uhie_host_model (
   // clock and register port
   input  wire logic                mclk,
   output var  uhie_pkg::uhie_req_t req
);
   logic [31:0] exp_q[$];
   // idle port at time zero
   initial req = '0;
   // one access: strobe one cycle, then scramble released fields
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic [31:0] wd;
      @(negedge mclk);
      // reserved positions written as zero; the port is assigned once per step
      wd = d & (a == uhie_pkg::OFS_FLAGS ? uhie_pkg::FLAG_MASK : uhie_pkg::ENABLE_MASK);
      req = '{rd: !w, wr: w, addr: a, wdata: (w ? wd : ~req.wdata)};
      if (!w)
         exp_q.push_back(d);
      @(negedge mclk);
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~req.wdata};
   endtask : acc
endmodule : uhie_host_model
`default_nettype wire

// File: bench/uhie_irq_core_tb.sv
// uhie_irq_core_tb: self-checking bench for the interrupt status/enable core.
// assumes the host model carries register traffic; events driven here.
`timescale 1ns/1ps
`default_nettype none
module uhie_irq_core_tb;
   localparam logic [7:0] FL = uhie_pkg::OFS_FLAGS;
   localparam logic [7:0] EN = uhie_pkg::OFS_ENABLES;
   localparam logic [7:0] DIS = uhie_pkg::OFS_EN_CLEAR;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   uhie_pkg::uhie_req_t req;
   uhie_pkg::uhie_evt_t evt = '0;
   logic [31:0] rdata_q;
   logic [1:0] overrun_count_q;
   logic rvalid_q, halt_q, done_wb_allow_q, host_irq_q, system_mgmt_irq_pin_n_q;
   logic smi2_n;
   int n_fail = 0;
   int n_checks = 0;
   int seed = 28214;
   int pb[8] = '{9, 8, 7, 6, 5, 2, 1, 0};
   int fb[8] = '{30, 6, 5, 5, 4, 2, 1, 0};
   int i;
   // 25 MHz clock
   always #20 mclk = ~mclk;
   uhie_host_model host_u (.mclk(mclk), .req(req));
   uhie_irq_core #(.HAS_SMI_PIN(1'b1)) dut_u (.mclk(mclk), .reset(reset), .req(req), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .evt(evt), .halt_q(halt_q), .done_wb_allow_q(done_wb_allow_q),
      .overrun_count_q(overrun_count_q), .host_irq_q(host_irq_q), .system_mgmt_irq_pin_n_q(system_mgmt_irq_pin_n_q));
   // second copy built without the smi pin, fed the same traffic
   uhie_irq_core #(.HAS_SMI_PIN(1'b0)) nosmi_u (.mclk(mclk), .reset(reset), .req(req), .rdata_q(),
      .rvalid_q(), .evt(evt), .halt_q(), .done_wb_allow_q(),
      .overrun_count_q(), .host_irq_q(), .system_mgmt_irq_pin_n_q(smi2_n));
   ////////////////////////////////////////////////////////////////////////////
   task automatic fail(input string m);
      $display("Error at %0t: %s", $time, m);
      n_fail++;
   endtask : fail
   task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) fail("read data");
   endtask : chk_rd
   task automatic chk_io(input logic [3:0] e);
      @(negedge mclk);
      n_checks++;
      if ({host_irq_q, system_mgmt_irq_pin_n_q, halt_q, done_wb_allow_q, smi2_n} !== {e, 1'b1}) fail("irq outputs");
   endtask : chk_io
   task automatic pulse(input int b);
      @(negedge mclk);
      evt[b] = 1'b1;
      @(negedge mclk);
      evt[b] = 1'b0;
   endtask : pulse
   task automatic test_done;
      if (n_fail == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   // compare each returned read with the oldest expectation
   always @(negedge mclk) begin
      if (rvalid_q === 1'b1) begin
         if (host_u.exp_q.size() == 0)
            fail("stray read");
         else
            chk_rd(host_u.exp_q.pop_front(), rdata_q);
      end
   end
   // main sequence
   initial begin
      repeat (12) @(negedge mclk);
      reset = 1'b0;
      host_u.acc(1'b0, FL, '0);
      host_u.acc(1'b0, 8'h00, '0);
      host_u.acc(1'b1, EN, '1);
      host_u.acc(1'b0, EN, uhie_pkg::ENABLE_MASK);
      host_u.acc(1'b1, DIS, 32'h1);
      host_u.acc(1'b0, DIS, 32'hc000_007e);
      host_u.acc(1'b1, EN, 32'h1);
      for (i = 0; i < 8; i++) begin
         pulse(pb[i]);
         chk_io({fb[i] != 30, fb[i] != 30, fb[i] == 4, fb[i] != 1});
         host_u.acc(1'b0, FL, 32'h1 << fb[i]);
         host_u.acc(1'b1, FL, $random(seed) & ~(32'h1 << fb[i]));
         host_u.acc(1'b0, FL, 32'h1 << fb[i]);
         // fatal flag: reset the controller first, then restore the enables
         if (fb[i] == uhie_pkg::BIT_FATAL) begin
            reset = 1'b1;
            @(negedge mclk);
            reset = 1'b0;
            host_u.acc(1'b1, EN, '1);
         end
         host_u.acc(1'b1, FL, 32'h1 << fb[i]);
         chk_io(4'b0101);
      end
      for (i = 1; i < 5; i++) begin
         chk_rd(32'(i % 4), {30'h0, overrun_count_q});
         pulse(0);
      end
      host_u.acc(1'b1, DIS, 32'h8000_0001);
      host_u.acc(1'b1, EN, 32'h8000_0000);
      chk_io(4'b0101);
      host_u.acc(1'b1, EN, 32'h1);
      chk_io(4'b1101);
      @(negedge mclk);
      evt.resume_sig = 1'b1;
      evt.sw_resume = 1'b1;
      @(negedge mclk);
      evt = '0;
      host_u.acc(1'b0, FL, 32'h1);
      pulse(4);
      host_u.acc(1'b0, FL, 32'h9);
      for (i = 0; i < 20 && host_u.exp_q.size() > 0; i++) @(negedge mclk);
      if (host_u.exp_q.size() > 0) fail("read timeout");
      test_done();
   end
endmodule : uhie_irq_core_tb
`default_nettype wire
